// ===== src/fan_cfg_defs.vh
`ifndef FAN_CFG_DEFS_VH
`define FAN_CFG_DEFS_VH

// ****************************************
// register offsets
// ****************************************
`define OFS_DELAY_LO      8'h36
`define OFS_DELAY_HI      8'h37
`define OFS_FAN1_MAX      8'h38
`define OFS_FAN2_MAX      8'h39
`define OFS_FAN3_MAX      8'h3A
`define OFS_MAIN_CFG      8'h40

// ****************************************
// reset values
// ****************************************
`define RST_DELAY_LO      8'h00
`define RST_DELAY_HI_BIT  1'h0
`define RST_MAX_DUTY      8'hFF
`define RST_MAIN_CFG      8'h01
`define DUTY_FULL         8'hFF
`define READ_ZERO         8'h00

// ****************************************
// main configuration bit positions
// ****************************************
`define CFG_RUN           0
`define CFG_LOCK          1
`define CFG_READY         2
`define CFG_FULL          3
`define CFG_CORE_FLAG     4
`define CFG_SPIN_FIXED    5
`define CFG_BUS_TO        6
`define CFG_LATCH_CLR     7

// ****************************************
// adjustment delay field
// ****************************************
`define DLY_LO_MSB        7
`define DLY_LO_LSB        6
`define DLY_HI_BIT        0
`define DLY_DEC_BASE      12'h008
`define DLY_INC_BASE      12'h010
`define DLY_CNT_ONE       12'h001
`define DLY_CNT_ZERO      12'h000

// ****************************************
// spin-up
// ****************************************
`define SPIN_PULSES       2'h2
`define SPIN_ONE          2'h1
`define SPIN_ZERO         2'h0

`endif

// ===== src/fan_duty_limiter.v
`timescale 1ns/1ps
`include "fan_cfg_defs.vh"

module fan_duty_limiter (
	// clock and reset
	input  wire       clk_sys,
	input  wire       srst,
	// configuration
	input  wire [7:0] max_duty,
	input  wire       fans_full_override,
	input  wire       spinup_fixed_timeout,
	input  wire       overtemp_use_max,
	// events
	input  wire [7:0] duty_request,
	input  wire       overtemp_event,
	input  wire       spinup_start,
	input  wire       spinup_timeout,
	input  wire       fan_speed_pulse,
	// result
	output reg  [7:0] duty_out,
	output wire       spinup_active
);

	reg       spin_reg;
	reg       spin_next;
	reg [1:0] pulse_cnt_reg;
	reg [1:0] pulse_cnt_next;
	reg [7:0] duty_next;

	assign spinup_active = spin_reg;

	// ****************************************
	// spin-up tracking
	// ****************************************
	always @* begin
		spin_next      = spin_reg;
		pulse_cnt_next = pulse_cnt_reg;
		if (spinup_start) begin
			spin_next      = 1'b1;
			pulse_cnt_next = `SPIN_ZERO;
		end else if (spin_reg) begin
			if (spinup_timeout) begin
				spin_next = 1'b0;
			end else if (fan_speed_pulse && !spinup_fixed_timeout) begin
				// early end after two pulses unless fixed timeout chosen
				if (pulse_cnt_reg == `SPIN_ONE) begin
					spin_next = 1'b0;
				end
				pulse_cnt_next = pulse_cnt_reg + `SPIN_ONE;
			end
		end
	end

	// ****************************************
	// duty selection
	// ****************************************
	always @* begin
		if (spin_reg) begin
			duty_next = `DUTY_FULL;
		end else if (overtemp_event) begin
			duty_next = overtemp_use_max ? max_duty : `DUTY_FULL;
		end else if (fans_full_override) begin
			duty_next = max_duty;
		end else if (duty_request > max_duty) begin
			duty_next = max_duty;
		end else begin
			duty_next = duty_request;
		end
	end

	always @(posedge clk_sys) begin
		if (srst) begin
			spin_reg      <= 1'b0;
			pulse_cnt_reg <= `SPIN_ZERO;
			duty_out      <= `RST_MAX_DUTY;
		end else begin
			spin_reg      <= spin_next;
			pulse_cnt_reg <= pulse_cnt_next;
			duty_out      <= duty_next;
		end
	end

endmodule

// ===== src/fan_control_config_lock_bank.v
// What this block does
// - three-bit remote-2 delay code, low bits at delay register bits 7:6
// - code 0 gives 8/16 cycles, each step doubles, code 7 gives 1024/2048
// - delay register ignores writes once lock is set
// - three max duty registers at fan1_max_duty..fan3_max_duty, reset 0xFF
// - each max duty register caps its fan drive output except during spin-up or over-temperature at full duty
// - max duty registers ignore writes while locked
// - over-temperature drives programmed max if config4 bit3, else full duty
// - main configuration at 0x40 resets to 0x01
// - run bit selects programmed limits, else power-up default limits
// - run bit stays writable under lock
// - lock bit is write-once, freezes lockable state until power cycle
// - ready bit read-only, set when device is fully powered up
// - full-speed bit drives fans at max duty, reset 0, never locked
// - bit 4 lockable flag with no control effect
// - bit 5 keeps drive high for whole spin-up timeout
// - bit 6 enables bus timeout, lockable
// - bit 7 clears latched over-temperature on latching variant, else reserved
`timescale 1ns/1ps
`include "fan_cfg_defs.vh"

module fan_control_config_lock_bank #(
	parameter HAS_LATCH = 0
) (
	// clock and reset
	input  wire        clk_sys,
	input  wire        srst,
	// register port
	input  wire [7:0]  reg_addr,
	input  wire        reg_wr_en,
	input  wire [7:0]  reg_wr_data,
	input  wire        reg_rd_en,
	output reg  [7:0]  reg_rd_data,
	output reg         reg_rd_valid,
	// device status
	input  wire        power_up_done,
	input  wire        overtemp_event,
	input  wire        overtemp_use_max,
	input  wire        monitor_tick,
	// fan control
	input  wire [23:0] duty_request,
	input  wire [2:0]  spinup_start,
	input  wire [2:0]  spinup_timeout,
	input  wire [2:0]  fan_speed_pulse,
	output wire [7:0]  fan_drive_1,
	output wire [7:0]  fan_drive_2,
	output wire [7:0]  fan_drive_3,
	output wire [2:0]  spinup_active,
	// configuration outputs
	output wire        use_programmed_limits,
	output wire        bus_timeout_enable,
	output wire        core_power_measure_flag,
	output wire        config_locked,
	output reg         latch_clear,
	// remote 2 adjustment delay
	output reg  [11:0] remote2_decrease_cycles,
	output reg  [11:0] remote2_increase_cycles,
	output reg         remote2_decrease_due,
	output reg         remote2_increase_due
);

	// ****************************************
	// storage
	// ****************************************
	reg  [7:0]  delay_lo_reg;
	reg         delay_hi_reg;
	reg  [7:0]  fan1_max_duty_reg;
	reg  [7:0]  fan2_max_duty_reg;
	reg  [7:0]  fan3_max_duty_reg;
	reg         monitor_run_reg;
	reg         lock_reg;
	reg         ready_reg;
	reg         fans_full_override_reg;
	reg         core_flag_reg;
	reg         spinup_fixed_timeout_reg;
	reg         bus_timeout_reg;
	reg  [11:0] dec_cnt_reg;
	reg  [11:0] dec_cnt_next;
	reg  [11:0] inc_cnt_reg;
	reg  [11:0] inc_cnt_next;
	reg  [7:0]  rd_mux;
	wire [2:0]  remote2_adjust_delay;
	wire        wr_open;
	wire        wr_cfg;
	wire [7:0]  main_cfg_view;
	wire [7:0]  drive [0:2];
	wire [7:0]  max_duty [0:2];

	assign remote2_adjust_delay = {delay_hi_reg,
		delay_lo_reg[`DLY_LO_MSB:`DLY_LO_LSB]};
	// lockable writes pass only before lock; refused ones vanish silently
	assign wr_open = reg_wr_en && !lock_reg;
	assign wr_cfg  = reg_wr_en && (reg_addr == `OFS_MAIN_CFG);

	assign use_programmed_limits   = monitor_run_reg;
	assign bus_timeout_enable      = bus_timeout_reg;
	assign core_power_measure_flag = core_flag_reg;
	assign config_locked           = lock_reg;

	assign max_duty[0] = fan1_max_duty_reg;
	assign max_duty[1] = fan2_max_duty_reg;
	assign max_duty[2] = fan3_max_duty_reg;
	assign fan_drive_1 = drive[0];
	assign fan_drive_2 = drive[1];
	assign fan_drive_3 = drive[2];

	assign main_cfg_view = {1'b0,
		bus_timeout_reg,
		spinup_fixed_timeout_reg,
		core_flag_reg,
		fans_full_override_reg,
		ready_reg,
		lock_reg,
		monitor_run_reg};

	// ****************************************
	// lockable registers
	// ****************************************
	always @(posedge clk_sys) begin
		if (srst) begin
			delay_lo_reg      <= `RST_DELAY_LO;
			delay_hi_reg      <= `RST_DELAY_HI_BIT;
			fan1_max_duty_reg <= `RST_MAX_DUTY;
			fan2_max_duty_reg <= `RST_MAX_DUTY;
			fan3_max_duty_reg <= `RST_MAX_DUTY;
			lock_reg          <= 1'b0;
			core_flag_reg     <= 1'b0;
			bus_timeout_reg   <= 1'b0;
		end else if (wr_open) begin
			case (reg_addr)
				`OFS_DELAY_LO: begin
					delay_lo_reg <= reg_wr_data;
				end
				`OFS_DELAY_HI: begin
					delay_hi_reg <= reg_wr_data[`DLY_HI_BIT];
				end
				`OFS_FAN1_MAX: begin
					fan1_max_duty_reg <= reg_wr_data;
				end
				`OFS_FAN2_MAX: begin
					fan2_max_duty_reg <= reg_wr_data;
				end
				`OFS_FAN3_MAX: begin
					fan3_max_duty_reg <= reg_wr_data;
				end
				`OFS_MAIN_CFG: begin
					// only srst, the power-on reset, can clear the lock
					lock_reg        <= reg_wr_data[`CFG_LOCK];
					core_flag_reg   <= reg_wr_data[`CFG_CORE_FLAG];
					bus_timeout_reg <= reg_wr_data[`CFG_BUS_TO];
				end
				default: begin
					lock_reg <= lock_reg;
				end
			endcase
		end
	end

	// ****************************************
	// bits that ignore the lock
	// ****************************************
	always @(posedge clk_sys) begin
		if (srst) begin
			monitor_run_reg          <= 1'b1;
			fans_full_override_reg   <= 1'b0;
			spinup_fixed_timeout_reg <= 1'b0;
			latch_clear              <= 1'b0;
		end else begin
			latch_clear <= 1'b0;
			if (wr_cfg) begin
				monitor_run_reg          <= reg_wr_data[`CFG_RUN];
				fans_full_override_reg   <= reg_wr_data[`CFG_FULL];
				spinup_fixed_timeout_reg <= reg_wr_data[`CFG_SPIN_FIXED];
				if (HAS_LATCH != 0) begin
					latch_clear <= reg_wr_data[`CFG_LATCH_CLR];
				end
			end
		end
	end

	// ****************************************
	// ready flag
	// ****************************************
	always @(posedge clk_sys) begin
		if (srst) begin
			ready_reg <= 1'b0;
		end else if (power_up_done) begin
			ready_reg <= 1'b1;
		end
	end

	// ****************************************
	// read path
	// ****************************************
	always @* begin
		case (reg_addr)
			`OFS_DELAY_LO: begin
				rd_mux = delay_lo_reg;
			end
			`OFS_DELAY_HI: begin
				rd_mux = {7'h00, delay_hi_reg};
			end
			`OFS_FAN1_MAX: begin
				rd_mux = fan1_max_duty_reg;
			end
			`OFS_FAN2_MAX: begin
				rd_mux = fan2_max_duty_reg;
			end
			`OFS_FAN3_MAX: begin
				rd_mux = fan3_max_duty_reg;
			end
			`OFS_MAIN_CFG: begin
				rd_mux = main_cfg_view;
			end
			default: begin
				rd_mux = `READ_ZERO;
			end
		endcase
	end

	always @(posedge clk_sys) begin
		if (srst) begin
			reg_rd_data  <= `READ_ZERO;
			reg_rd_valid <= 1'b0;
		end else begin
			reg_rd_valid <= reg_rd_en;
			if (reg_rd_en) begin
				reg_rd_data <= rd_mux;
			end
		end
	end

	// ****************************************
	// remote 2 adjustment delay
	// ****************************************
	always @* begin
		dec_cnt_next = dec_cnt_reg;
		inc_cnt_next = inc_cnt_reg;
		if (!monitor_run_reg) begin
			// hold off adjustment while limits are defaults
			dec_cnt_next = `DLY_CNT_ZERO;
			inc_cnt_next = `DLY_CNT_ZERO;
		end else if (monitor_tick) begin
			if (dec_cnt_reg + `DLY_CNT_ONE >= remote2_decrease_cycles) begin
				dec_cnt_next = `DLY_CNT_ZERO;
			end else begin
				dec_cnt_next = dec_cnt_reg + `DLY_CNT_ONE;
			end
			if (inc_cnt_reg + `DLY_CNT_ONE >= remote2_increase_cycles) begin
				inc_cnt_next = `DLY_CNT_ZERO;
			end else begin
				inc_cnt_next = inc_cnt_reg + `DLY_CNT_ONE;
			end
		end
	end

	always @(posedge clk_sys) begin
		if (srst) begin
			remote2_decrease_cycles <= `DLY_DEC_BASE;
			remote2_increase_cycles <= `DLY_INC_BASE;
			dec_cnt_reg             <= `DLY_CNT_ZERO;
			inc_cnt_reg             <= `DLY_CNT_ZERO;
			remote2_decrease_due    <= 1'b0;
			remote2_increase_due    <= 1'b0;
		end else begin
			remote2_decrease_cycles <= `DLY_DEC_BASE << remote2_adjust_delay;
			remote2_increase_cycles <= `DLY_INC_BASE << remote2_adjust_delay;
			dec_cnt_reg             <= dec_cnt_next;
			inc_cnt_reg             <= inc_cnt_next;
			remote2_decrease_due    <= monitor_run_reg && monitor_tick &&
				(dec_cnt_reg + `DLY_CNT_ONE >= remote2_decrease_cycles);
			remote2_increase_due    <= monitor_run_reg && monitor_tick &&
				(inc_cnt_reg + `DLY_CNT_ONE >= remote2_increase_cycles);
		end
	end

	// ****************************************
	// per-fan duty limiting
	// ****************************************
	genvar i;
	generate
		for (i = 0; i < 3; i = i + 1) begin : g_fan
			fan_duty_limiter u_lim (
				.clk_sys              (clk_sys),
				.srst                 (srst),
				.max_duty             (max_duty[i]),
				.fans_full_override   (fans_full_override_reg),
				.spinup_fixed_timeout (spinup_fixed_timeout_reg),
				.overtemp_use_max     (overtemp_use_max),
				.duty_request         (duty_request[8*i+7:8*i]),
				.overtemp_event       (overtemp_event),
				.spinup_start         (spinup_start[i]),
				.spinup_timeout       (spinup_timeout[i]),
				.fan_speed_pulse      (fan_speed_pulse[i]),
				.duty_out             (drive[i]),
				.spinup_active        (spinup_active[i])
			);
		end
	endgenerate

endmodule

// ===== verification/fan_bank_monitor.sv
`timescale 1ns/1ps
// ****
// bank checks
// ****
module fan_bank_monitor #(
	parameter HAS_LATCH = 0
) (
	// clock
	input wire        clk_sys,
	input wire        srst,
	// register port
	input wire [7:0]  reg_addr,
	input wire        reg_wr_en,
	input wire [7:0]  reg_wr_data,
	input wire        reg_rd_en,
	input wire        reg_rd_valid,
	// control
	input wire        overtemp_event,
	input wire        overtemp_use_max,
	input wire [7:0]  fan_drive_1,
	input wire        use_programmed_limits,
	input wire        bus_timeout_enable,
	input wire        config_locked,
	input wire        latch_clear,
	input wire [11:0] remote2_decrease_cycles,
	input wire [11:0] remote2_increase_cycles,
	input wire        remote2_decrease_due
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (srst);
	a_rd_answer: assert property (reg_rd_en |=> reg_rd_valid)
		else $error("no read answer");
	a_lock_kept: assert property (config_locked |=> config_locked)
		else $error("lock dropped");
	a_bto_frozen: assert property (config_locked |=> $stable(bus_timeout_enable))
		else $error("timeout bit moved under lock");
	a_run_write: assert property (reg_wr_en && reg_addr == 8'h40
		|=> use_programmed_limits == $past(reg_wr_data[0]))
		else $error("run bit not written");
	a_inc_double: assert property (remote2_increase_cycles == remote2_decrease_cycles << 1)
		else $error("increase not twice decrease");
	a_ot_full: assert property (overtemp_event && !overtemp_use_max |=> fan_drive_1 == 8'hFF)
		else $error("overtemp not full duty");
	a_due_single: assert property (remote2_decrease_due |=> !remote2_decrease_due)
		else $error("due pulse too long");
	a_latch_idle: assert property (HAS_LATCH == 0 |-> !latch_clear)
		else $error("latch clear on base variant");
	a_latch_pulse: assert property (HAS_LATCH != 0 && reg_wr_en && reg_addr == 8'h40
		&& reg_wr_data[7] |=> latch_clear)
		else $error("latch clear pulse missing");
endmodule

bind fan_control_config_lock_bank fan_bank_monitor #(.HAS_LATCH(HAS_LATCH)) i_fan_bank_monitor (
	.clk_sys, .srst, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en, .reg_rd_valid,
	.overtemp_event, .overtemp_use_max, .fan_drive_1, .use_programmed_limits,
	.bus_timeout_enable, .config_locked, .latch_clear, .remote2_decrease_cycles,
	.remote2_increase_cycles, .remote2_decrease_due
);

// ===== verification/smbus_host_model.sv
`timescale 1ns/1ps
// ****
// register port host
// ****
module smbus_host_model (
	// clock
	input  wire       clk_sys,
	// register port
	output reg  [7:0] reg_addr    = 8'h00,
	output reg        reg_wr_en   = 1'b0,
	output reg  [7:0] reg_wr_data = 8'h00,
	output reg        reg_rd_en   = 1'b0,
	input  wire [7:0] reg_rd_data,
	input  wire       reg_rd_valid
);
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(posedge clk_sys);
			reg_addr    <= a;
			reg_wr_data <= d;
			reg_wr_en   <= 1'b1;
			@(posedge clk_sys);
			// inverted leftovers so a late sample cannot pass
			reg_wr_en   <= 1'b0;
			reg_addr    <= ~a;
			reg_wr_data <= ~d;
		end
	endtask
	task rd(input [7:0] a, output [7:0] d);
		begin
			@(posedge clk_sys);
			reg_addr  <= a;
			reg_rd_en <= 1'b1;
			@(posedge clk_sys);
			reg_rd_en <= 1'b0;
			@(posedge clk_sys);
			d = reg_rd_valid ? reg_rd_data : 8'hXX;
			reg_addr  <= ~a;
		end
	endtask
endmodule

// ===== verification/testbench.sv
`timescale 1ns/1ps
// ****
// bench top
// ****
module testbench;
	reg         clk_sys          = 1'b0;
	reg         srst             = 1'b1;
	reg         power_up_done    = 1'b0;
	reg         overtemp_event   = 1'b0;
	reg         overtemp_use_max = 1'b0;
	reg         monitor_tick     = 1'b0;
	reg  [23:0] duty_request     = 24'h000000;
	reg  [2:0]  spinup_start     = 3'h0;
	reg  [2:0]  spinup_timeout   = 3'h0;
	reg  [2:0]  fan_speed_pulse  = 3'h0;
	wire [7:0]  reg_addr;
	wire        reg_wr_en;
	wire [7:0]  reg_wr_data;
	wire        reg_rd_en;
	wire [7:0]  reg_rd_data;
	wire        reg_rd_valid;
	wire [7:0]  fan_drive_1;
	wire [7:0]  fan_drive_2;
	wire [7:0]  fan_drive_3;
	wire        use_programmed_limits;
	wire        latch_clear;
	wire        latch_clear_alt;
	wire        remote2_decrease_due;
	wire        remote2_increase_due;
	wire [2:0]  spinup_active;
	wire        bus_timeout_enable;
	wire        core_power_measure_flag;
	wire [11:0] remote2_decrease_cycles;
	wire [11:0] remote2_increase_cycles;
	reg  [7:0]  rdat;
	integer     err_total   = 0;
	integer     checks_done = 0;
	integer     i;
	integer     n_dec;
	integer     n_inc;
	integer     first_dec;

	fan_control_config_lock_bank i_fan_control_config_lock_bank (
		.clk_sys, .srst, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en, .reg_rd_data,
		.reg_rd_valid, .power_up_done, .overtemp_event, .overtemp_use_max, .monitor_tick,
		.duty_request, .spinup_start, .spinup_timeout, .fan_speed_pulse, .fan_drive_1,
		.fan_drive_2, .fan_drive_3, .spinup_active, .use_programmed_limits,
		.bus_timeout_enable, .core_power_measure_flag, .config_locked(), .latch_clear,
		.remote2_decrease_cycles, .remote2_increase_cycles, .remote2_decrease_due,
		.remote2_increase_due
	);
	// latching variant shares the bus; only its clear pulse is watched
	fan_control_config_lock_bank #(.HAS_LATCH(1)) i_fan_control_config_lock_bank_latch (
		.clk_sys, .srst, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en, .reg_rd_data(),
		.reg_rd_valid(), .power_up_done, .overtemp_event, .overtemp_use_max, .monitor_tick,
		.duty_request, .spinup_start, .spinup_timeout, .fan_speed_pulse, .fan_drive_1(),
		.fan_drive_2(), .fan_drive_3(), .spinup_active(), .use_programmed_limits(),
		.bus_timeout_enable(), .core_power_measure_flag(), .config_locked(),
		.latch_clear(latch_clear_alt), .remote2_decrease_cycles(),
		.remote2_increase_cycles(), .remote2_decrease_due(), .remote2_increase_due()
	);
	smbus_host_model i_smbus_host_model (
		.clk_sys, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en, .reg_rd_data, .reg_rd_valid
	);

	initial begin
		forever #4 clk_sys = ~clk_sys;
	end

	task chk(input [11:0] got, input [11:0] exp);
		begin
			checks_done = checks_done + 1;
			if (got !== exp) begin
				err_total = err_total + 1;
				$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task end_sim;
		begin
			if (err_total == 0 && checks_done > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	task w(input [7:0] a, input [7:0] d);
		i_smbus_host_model.wr(a, d);
	endtask
	task r(input [7:0] a, input [7:0] exp);
		begin
			i_smbus_host_model.rd(a, rdat);
			chk(rdat, exp);
		end
	endtask

	task t_reset;
		begin
			for (i = 0; i < 3; i = i + 1) begin
				r(8'h38 + i[7:0], 8'hFF);
			end
			r(8'h40, 8'h01);
			r(8'h00, 8'h00);
			power_up_done <= 1'b1;
			r(8'h40, 8'h05);
		end
	endtask
	task t_delay;
		begin
			for (i = 0; i < 8; i = i + 1) begin
				w(8'h36, {i[1:0], 6'h15});
				w(8'h37, {7'h00, i[2]});
				repeat (2) @(posedge clk_sys);
				chk(remote2_decrease_cycles, 12'h008 << i);
				chk(remote2_increase_cycles, 12'h010 << i);
			end
		end
	endtask
	task t_cap;
		begin
			w(8'h38, 8'h80);
			w(8'h39, 8'h40);
			w(8'h3A, 8'h20);
			duty_request <= 24'hC0C0C0;
			repeat (3) @(posedge clk_sys);
			chk(fan_drive_1, 8'h80);
			chk(fan_drive_2, 8'h40);
			chk(fan_drive_3, 8'h20);
			overtemp_event <= 1'b1;
			repeat (3) @(posedge clk_sys);
			chk(fan_drive_1, 8'hFF);
			overtemp_use_max <= 1'b1;
			repeat (3) @(posedge clk_sys);
			chk(fan_drive_1, 8'h80);
			overtemp_event <= 1'b0;
			duty_request <= 24'h000010;
		end
	endtask
	task t_lock;
		begin
			w(8'h40, 8'h53);
			r(8'h40, 8'h57);
			w(8'h40, 8'h88);
			@(negedge clk_sys);
			chk(latch_clear_alt, 1'b1);
			chk(latch_clear, 1'b0);
			chk(use_programmed_limits, 1'b0);
			r(8'h40, 8'h5E);
			chk(fan_drive_1, 8'h80);
			chk(bus_timeout_enable, 1'b1);
			chk(core_power_measure_flag, 1'b1);
			w(8'h38, 8'h11);
			r(8'h38, 8'h80);
			w(8'h36, 8'h00);
			w(8'h37, 8'h00);
			repeat (2) @(posedge clk_sys);
			chk(remote2_decrease_cycles, 12'h400);
		end
	endtask
	// two separate speed pulses, enough to end a normal spin-up
	task spin_pulses;
		begin
			spinup_start <= 3'h1;
			@(posedge clk_sys);
			spinup_start <= 3'h0;
			for (i = 0; i < 4; i = i + 1) begin
				@(posedge clk_sys);
				fan_speed_pulse <= {2'h0, ~i[0]};
			end
			repeat (3) @(posedge clk_sys);
		end
	endtask
	task t_spin;
		begin
			w(8'h40, 8'h20);
			spin_pulses;
			chk(spinup_active, 3'h1);
			chk(fan_drive_1, 8'hFF);
			spinup_timeout <= 3'h1;
			@(posedge clk_sys);
			spinup_timeout <= 3'h0;
			repeat (3) @(posedge clk_sys);
			chk(spinup_active, 3'h0);
			w(8'h40, 8'h00);
			spin_pulses;
			chk(spinup_active, 3'h0);
		end
	endtask
	// code stays 7 under lock: 1024/2048 ticks, one tick every other cycle
	task t_tick;
		begin
			w(8'h40, 8'h01);
			@(negedge clk_sys);
			chk(use_programmed_limits, 1'b1);
			@(posedge clk_sys);
			n_dec     = 0;
			n_inc     = 0;
			first_dec = 0;
			for (i = 1; i <= 2048; i = i + 1) begin
				monitor_tick <= 1'b1;
				@(posedge clk_sys);
				monitor_tick <= 1'b0;
				@(negedge clk_sys);
				if (remote2_decrease_due) begin
					n_dec = n_dec + 1;
					if (n_dec == 1)
						first_dec = i;
				end
				if (remote2_increase_due)
					n_inc = n_inc + 1;
				@(posedge clk_sys);
			end
			chk(first_dec[11:0], 12'h400);
			chk(n_dec[11:0], 12'h002);
			chk(n_inc[11:0], 12'h001);
		end
	endtask

	initial begin
		repeat (20) @(posedge clk_sys);
		srst <= 1'b0;
		t_reset;
		t_delay;
		t_cap;
		t_lock;
		t_spin;
		t_tick;
		end_sim;
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		err_total = err_total + 1;
		end_sim;
	end
endmodule
